// file: src/abb_dev.sv
// Design decisions made here: the placing of the registers and register access over the two-wire link.
`timescale 1ns/1ns
module abb_dev #(
  parameter bit DUAL_SUPPLY = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  abb_link_if.dev link,
  input wire logic connect_sense_reset_in,
  input wire logic supply_lockout,
  input wire logic card_side_supply_lockout,
  input wire logic [abb_pkg::ADDR_LOW_W-1:0] addr_code,
  input wire logic general_pin_one_in,
  output logic general_pin_one_out,
  output logic general_pin_one_oe,
  input wire logic general_pin_two_in,
  output logic general_pin_two_out,
  output logic general_pin_two_oe,
  output logic precharge_backplane,
  output logic precharge_card,
  output logic connect_enable,
  output logic accel_enable
);
  logic [11:0] raw;
  logic [11:0] syn;
  logic scl_s;
  logic sda_s;
  logic connect_sense_reset_in_s;
  logic lock_s;
  logic card_lock_s;
  logic gp1_s;
  logic gp2_s;
  logic [abb_pkg::ADDR_LOW_W-1:0] addr_s;
  logic scl_q;
  logic sda_q;
  abb_pkg::abb_slv_state_t state;
  logic [3:0] cnt;
  logic [7:0] shreg;
  logic [7:0] tx;
  logic rw;
  logic in_ack;
  logic mnack;
  logic drive_low;
  logic [7:0] cfg;

  // Every pin-level input crosses into pclk first
  assign raw = {addr_code, general_pin_two_in, general_pin_one_in, card_side_supply_lockout,
                supply_lockout, connect_sense_reset_in, link.sda, link.scl};
  abb_sync #(.WIDTH(12)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(raw),
    .q(syn)
  );
  assign scl_s = syn[0];
  assign sda_s = syn[1];
  assign connect_sense_reset_in_s = syn[2];
  assign lock_s = syn[3];
  assign card_lock_s = syn[4];
  assign gp1_s = syn[5];
  assign gp2_s = syn[6];
  assign addr_s = syn[11:7];

  // Previous line levels for edge and condition detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'b0;
      sda_q <= 1'b0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // Bus events and decode
  logic bus_on;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic addr_hit;
  logic slot_fall;
  logic slot_rise;
  logic cfg_we;
  logic [7:0] rd_byte;
  assign bus_on = connect_sense_reset_in_s & ~lock_s;
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_c = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_c = scl_s & scl_q & ~sda_q & sda_s;
  assign addr_hit = (shreg[7:1] == {abb_pkg::ADDR_TOP, addr_s});
  assign slot_fall = bus_on & ~start_c & ~stop_c & (state != abb_pkg::ABB_S_IDLE) & scl_fall;
  assign slot_rise = bus_on & ~start_c & ~stop_c & (state != abb_pkg::ABB_S_IDLE) & scl_rise;
  assign cfg_we = slot_fall & (state == abb_pkg::ABB_S_WRITE) & (cnt == abb_pkg::BIT_ACK);
  // Reads report pin levels in place of the two output values
  assign rd_byte = {gp2_s, gp1_s, cfg[5:0]};

  // Slave engine; it never touches the clock line, so it must keep pace
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= abb_pkg::ABB_S_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      rw <= 1'b0;
      in_ack <= 1'b0;
      mnack <= 1'b0;
      drive_low <= 1'b0;
    end else if (!bus_on) begin
      state <= abb_pkg::ABB_S_IDLE;
      cnt <= 4'h0;
      in_ack <= 1'b0;
      drive_low <= 1'b0;
    end else if (start_c) begin
      state <= abb_pkg::ABB_S_ADDR;
      cnt <= 4'h0;
      in_ack <= 1'b0;
      drive_low <= 1'b0;
    end else if (stop_c) begin
      state <= abb_pkg::ABB_S_IDLE;
      in_ack <= 1'b0;
      drive_low <= 1'b0;
    end else if (slot_rise) begin
      // Data is sampled on the rising clock edge
      if (cnt != abb_pkg::BIT_ACK && state != abb_pkg::ABB_S_READ) begin
        shreg <= {shreg[6:0], sda_s};
      end
      if (cnt == abb_pkg::BIT_ACK && state == abb_pkg::ABB_S_READ) begin
        mnack <= sda_s;
      end
      cnt <= (cnt == abb_pkg::BIT_ACK) ? 4'h0 : cnt + 4'h1;
    end else if (slot_fall) begin
      if (cnt == abb_pkg::BIT_ACK) begin
        // Acknowledge slot opens; on an address hit or a written byte the data line is held low until the next falling edge
        in_ack <= 1'b1;
        case (state)
          abb_pkg::ABB_S_ADDR: begin
            if (addr_hit) begin
              drive_low <= 1'b1;
              rw <= shreg[0];
            end else begin
              state <= abb_pkg::ABB_S_IDLE;
            end
          end
          abb_pkg::ABB_S_WRITE: drive_low <= 1'b1;
          default: drive_low <= 1'b0;
        endcase
      end else if (in_ack) begin
        // Acknowledge slot closes; no byte limit, so keep going
        in_ack <= 1'b0;
        case (state)
          abb_pkg::ABB_S_ADDR: begin
            if (rw) begin
              state <= abb_pkg::ABB_S_READ;
              tx <= rd_byte;
              drive_low <= ~rd_byte[7];
            end else begin
              state <= abb_pkg::ABB_S_WRITE;
              drive_low <= 1'b0;
            end
          end
          abb_pkg::ABB_S_READ: begin
            if (mnack) begin
              state <= abb_pkg::ABB_S_IDLE;
              drive_low <= 1'b0;
            end else begin
              tx <= rd_byte;
              drive_low <= ~rd_byte[7];
            end
          end
          default: drive_low <= 1'b0;
        endcase
      end else if (state == abb_pkg::ABB_S_READ) begin
        drive_low <= ~tx[6];
        tx <= {tx[6:0], 1'b0};
      end
    end
  end

  // Configuration byte, held at defaults while sense is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= abb_pkg::CFG_RESET;
    end else if (!connect_sense_reset_in_s) begin
      cfg <= abb_pkg::CFG_RESET;
    end else if (cfg_we) begin
      cfg <= shreg;
    end
  end

  // Pin driver: {out, oe} for a mode and value
  function automatic logic [1:0] pin_drive(input logic [1:0] mode, input logic val);
    case (mode)
      abb_pkg::ABB_PIN_OD: pin_drive = {1'b0, ~val};
      abb_pkg::ABB_PIN_PP: pin_drive = {val, 1'b1};
      default: pin_drive = 2'b00;
    endcase
  endfunction : pin_drive

  logic [1:0] pin1;
  logic [1:0] pin2;
  assign pin1 = pin_drive(cfg[abb_pkg::CFG_MODE1_LSB +: 2], cfg[abb_pkg::CFG_VAL1_BIT]);
  // The dual-supply variant has no second pin; it stays an input
  assign pin2 = DUAL_SUPPLY ? 2'b00 :
                pin_drive(cfg[abb_pkg::CFG_MODE2_LSB +: 2], cfg[abb_pkg::CFG_VAL2_BIT]);
  assign general_pin_one_out = pin1[1];
  assign general_pin_one_oe = pin1[0];
  assign general_pin_two_out = pin2[1];
  assign general_pin_two_oe = pin2[0];

  // Power and connection controls
  logic any_lock;
  assign any_lock = lock_s | (DUAL_SUPPLY & card_lock_s);
  assign precharge_backplane = lock_s;
  assign precharge_card = DUAL_SUPPLY ? card_lock_s : lock_s;
  assign connect_enable = cfg[abb_pkg::CFG_CONNECT_SENSE_RESET_IN_BIT] & connect_sense_reset_in_s & ~any_lock;
  assign accel_enable = cfg[abb_pkg::CFG_ACCEL_BIT];

  // Open-drain outputs only; clock is never pulled
  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe = drive_low;
  assign link.dev_scl_out = 1'b0;
  assign link.dev_scl_oe = 1'b0;
endmodule : abb_dev

// file: src/abb_host.sv
`timescale 1ns/1ns
module abb_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  abb_link_if.host link
);
  abb_pkg::abb_host_state_t state;
  logic [1:0] step;
  logic [3:0] bitn;
  logic byte1;
  logic [7:0] txb;
  logic [7:0] rx;
  logic [7:0] rdata;
  logic ack_bit;
  logic anack;
  logic dnack;
  logic cmd_rd;
  logic [7:0] cmd_data;
  logic [15:0] div;
  logic [15:0] div_cnt;
  logic scl_low;
  logic sda_low;
  logic sda_s;

  abb_sync #(.WIDTH(1)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(link.sda),
    .q(sda_s)
  );

  // APB decode; zero wait states
  logic hit_cmd;
  logic hit_st;
  logic hit_div;
  logic mapped;
  logic apb_wr;
  logic busy;
  logic tick;
  logic rel;
  logic drive;
  logic [31:0] st_word;
  assign hit_cmd = (paddr == abb_pkg::REG_CMD);
  assign hit_st = (paddr == abb_pkg::REG_STATUS);
  assign hit_div = (paddr == abb_pkg::REG_DIV);
  assign mapped = hit_cmd | hit_st | hit_div;
  assign apb_wr = psel & penable & pwrite & mapped;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign busy = (state != abb_pkg::ABB_H_IDLE);
  assign st_word = {16'h0000, rdata, 5'h00, dnack, anack, busy};
  assign tick = (div_cnt == 16'h0000);
  // Read byte and the acknowledge slot leave data released
  assign rel = (bitn == abb_pkg::BIT_ACK) | (byte1 & cmd_rd);
  assign drive = ~rel & ~txb[7];

  // Read data registered in the setup cycle, valid in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable) begin
      prdata <= hit_st ? st_word : (hit_div ? {16'h0000, div} : 32'h00000000);
    end
  end

  // Divider register; a busy transfer keeps its rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= abb_pkg::DIV_RESET;
      div_cnt <= abb_pkg::DIV_RESET;
    end else begin
      if (apb_wr & hit_div & ~busy) begin
        div <= pwdata[15:0];
      end
      div_cnt <= (tick | ~busy) ? div : div_cnt - 16'h0001;
    end
  end

  // Transfer engine: start, address, one data byte, stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= abb_pkg::ABB_H_IDLE;
      step <= 2'b00;
      bitn <= 4'h0;
      byte1 <= 1'b0;
      txb <= 8'h00;
      rx <= 8'h00;
      rdata <= 8'h00;
      ack_bit <= 1'b1;
      anack <= 1'b0;
      dnack <= 1'b0;
      cmd_rd <= 1'b0;
      cmd_data <= 8'h00;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
    end else if (!busy) begin
      if (apb_wr & hit_cmd) begin
        state <= abb_pkg::ABB_H_START;
        step <= 2'b00;
        bitn <= 4'h0;
        byte1 <= 1'b0;
        anack <= 1'b0;
        dnack <= 1'b0;
        cmd_rd <= pwdata[abb_pkg::CMD_READ_BIT];
        cmd_data <= pwdata[abb_pkg::CMD_DATA_LSB +: 8];
        // Seven address bits go out first, the direction bit last
        txb <= {pwdata[abb_pkg::CMD_ADDR_LSB +: 7], pwdata[abb_pkg::CMD_READ_BIT]};
      end
    end else if (tick) begin
      step <= step + 2'b01;
      case (state)
        abb_pkg::ABB_H_START: begin
          if (step == 2'b00) begin
            sda_low <= 1'b1;
          end else begin
            scl_low <= 1'b1;
            state <= abb_pkg::ABB_H_BITS;
            step <= 2'b00;
          end
        end
        abb_pkg::ABB_H_BITS: begin
          case (step)
            2'b00: sda_low <= drive;
            2'b01: scl_low <= 1'b0;
            2'b10: begin
              if (bitn == abb_pkg::BIT_ACK) begin
                ack_bit <= sda_s;
              end else begin
                rx <= {rx[6:0], sda_s};
              end
            end
            default: begin
              scl_low <= 1'b1;
              if (bitn != abb_pkg::BIT_ACK) begin
                bitn <= bitn + 4'h1;
                txb <= {txb[6:0], 1'b1};
              end else if (!byte1) begin
                bitn <= 4'h0;
                if (ack_bit) begin
                  anack <= 1'b1;
                  state <= abb_pkg::ABB_H_STOP;
                end else begin
                  byte1 <= 1'b1;
                  txb <= cmd_rd ? 8'hFF : cmd_data;
                end
              end else begin
                if (cmd_rd) begin
                  rdata <= rx;
                end
                dnack <= ack_bit & ~cmd_rd;
                state <= abb_pkg::ABB_H_STOP;
              end
            end
          endcase
        end
        abb_pkg::ABB_H_STOP: begin
          if (step == 2'b00) begin
            sda_low <= 1'b1;
          end else if (step == 2'b01) begin
            scl_low <= 1'b0;
          end else begin
            sda_low <= 1'b0;
            state <= abb_pkg::ABB_H_IDLE;
          end
        end
        default: state <= abb_pkg::ABB_H_IDLE;
      endcase
    end
  end

  // Open-drain only; a released line is pulled high by the wire
  assign link.host_scl_out = 1'b0;
  assign link.host_scl_oe = scl_low;
  assign link.host_sda_out = 1'b0;
  assign link.host_sda_oe = sda_low;
endmodule : abb_host

// file: src/abb_link_if.sv
`timescale 1ns/1ns
interface abb_link_if;
  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_scl_out;
  logic dev_scl_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // Wired-AND with pull-up: any enabled driver pulls the line low
  assign scl = ~(host_scl_oe | dev_scl_oe);
  assign sda = ~(host_sda_oe | dev_sda_oe);
  modport dev (
    input scl,
    input sda,
    output dev_scl_out,
    output dev_scl_oe,
    output dev_sda_out,
    output dev_sda_oe
  );
  modport host (
    input scl,
    input sda,
    output host_scl_out,
    output host_scl_oe,
    output host_sda_out,
    output host_sda_oe
  );
endinterface : abb_link_if

// file: src/abb_pkg.sv
package abb_pkg;
  // Slave address: two fixed upper bits above the converter code
  localparam logic [1:0] ADDR_TOP = 2'b11;
  localparam int ADDR_LOW_W = 5;
  // Configuration byte layout
  localparam int CFG_CONNECT_SENSE_RESET_IN_BIT = 0;
  localparam int CFG_ACCEL_BIT = 1;
  localparam int CFG_MODE1_LSB = 2;
  localparam int CFG_MODE2_LSB = 4;
  localparam int CFG_VAL1_BIT = 6;
  localparam int CFG_VAL2_BIT = 7;
  localparam logic [7:0] CFG_RESET = 8'hC0;
  // Bit counter value of the acknowledge slot
  localparam logic [3:0] BIT_ACK = 4'h8;
  typedef enum logic [1:0] {
    ABB_PIN_OD = 2'b00,
    ABB_PIN_PP = 2'b01,
    ABB_PIN_IN = 2'b10
  } abb_pin_mode_t;
  typedef enum logic [1:0] {
    ABB_S_IDLE = 2'b00,
    ABB_S_ADDR = 2'b01,
    ABB_S_WRITE = 2'b10,
    ABB_S_READ = 2'b11
  } abb_slv_state_t;
  typedef enum logic [1:0] {
    ABB_H_IDLE = 2'b00,
    ABB_H_START = 2'b01,
    ABB_H_BITS = 2'b10,
    ABB_H_STOP = 2'b11
  } abb_host_state_t;
  // Controller registers on APB
  localparam logic [11:0] REG_CMD = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_DIV = 12'h008;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_READ_BIT = 7;
  localparam int CMD_DATA_LSB = 8;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ANACK_BIT = 1;
  localparam int ST_DNACK_BIT = 2;
  localparam int ST_RDATA_LSB = 8;
  // Link timing: one quarter of a bus clock period
  localparam int CLK_PERIOD_NS = 20;
  localparam int QUARTER_NS = 2500;
  localparam int QUARTER_CYC = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] DIV_RESET = 16'(QUARTER_CYC);
endpackage : abb_pkg

// file: src/abb_sync.sv
`timescale 1ns/1ns
module abb_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // Two flops; only the second one is visible outside
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : abb_sync

// file: tb/abb_link_props.sv
`timescale 1ns/1ns
// Watches the shared link and the device's control outputs
module abb_link_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic host_scl_out,
  input wire logic host_sda_out,
  input wire logic dev_scl_out,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  input wire logic connect_sense_reset_in,
  input wire logic supply_lockout,
  input wire logic connect_enable,
  input wire logic accel_enable,
  input wire logic general_pin_one_oe,
  input wire logic general_pin_two_oe,
  input wire logic precharge_backplane
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Line drivers: pull low or release, never stretch
  property p_no_stretch; dev_scl_oe == 1'b0; endproperty
  a_no_stretch: assert property (p_no_stretch) else $error("clock held low");
  property p_pull_only;
    !host_scl_out && !host_sda_out && !dev_scl_out && !dev_sda_out;
  endproperty
  a_pull_only: assert property (p_pull_only) else $error("line driven high");
  // Data moves only while the clock is low, so no false start or stop
  property p_sda_change; $changed(dev_sda_oe) |-> !scl; endproperty
  a_sda_change: assert property (p_sda_change) else $error("data moved, clock high");
  // A pulled bit lasts at least 8 pclk cycles, not a glitch
  property p_sda_hold; $rose(dev_sda_oe) |-> dev_sda_oe [*8]; endproperty
  a_sda_hold: assert property (p_sda_hold) else $error("pull too short");
  // Sense low: silent bus and default settings; 2 sync stages plus a register
  property p_sense_silent; !connect_sense_reset_in [*4] |-> !dev_sda_oe; endproperty
  a_sense_silent: assert property (p_sense_silent) else $error("answered, sense low");
  property p_sense_defaults;
    !connect_sense_reset_in [*4] |->
      !accel_enable && !general_pin_one_oe && !general_pin_two_oe;
  endproperty
  a_sense_defaults: assert property (p_sense_defaults) else $error("not default");
  property p_lock_silent; supply_lockout [*4] |-> !dev_sda_oe; endproperty
  a_lock_silent: assert property (p_lock_silent) else $error("answered in lockout");
  // Precharge follows lockout after the synchroniser
  property p_pre_on; supply_lockout [*3] |-> precharge_backplane; endproperty
  a_pre_on: assert property (p_pre_on) else $error("precharge off in lockout");
  property p_pre_off; !supply_lockout [*3] |-> !precharge_backplane; endproperty
  a_pre_off: assert property (p_pre_off) else $error("precharge on");
  property p_connect_sense_reset_in_gate;
    (!connect_sense_reset_in || supply_lockout) [*3] |-> !connect_enable;
  endproperty
  a_connect_sense_reset_in_gate: assert property (p_connect_sense_reset_in_gate) else $error("connection not gated");

  // Main scenarios
  c_ack: cover property ($rose(dev_sda_oe));
  c_connect_sense_reset_in: cover property ($rose(connect_enable));
  c_pre: cover property ($rose(precharge_backplane));
endmodule : abb_link_props

// file: tb/test_addressable_bus_buffer_ctrl.sv
`timescale 1ns/1ns
// Host controller and device face each other over one link
module test_addressable_bus_buffer_ctrl;
  typedef struct packed {
    logic [31:0] m;
    logic e;
    logic [31:0] v;
  } abb_note_t;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rdata;
  logic pready;
  logic pslverr;
  logic sense;
  logic lock;
  logic card_lock;
  logic [4:0] addr_code;
  logic [6:0] own;
  logic gp1_in;
  logic gp2_in;
  logic gp1_out;
  logic gp1_oe;
  logic gp2_out;
  logic gp2_oe;
  logic pre_bp;
  logic pre_card;
  logic connect_sense_reset_in_en;
  logic accel_en;
  int fails;
  int n_compared;
  integer seed;
  abb_note_t note_q[$];
  abb_note_t cur;
  logic [7:0] cfgs [4] = '{8'h67, 8'h10, 8'h3F, 8'hC0};

  assign own = {abb_pkg::ADDR_TOP, addr_code};

  abb_link_if link ();
  abb_dev u_abb_dev (
    .pclk(pclk),
    .presetn(presetn),
    .link(link.dev),
    .connect_sense_reset_in(sense),
    .supply_lockout(lock),
    .card_side_supply_lockout(card_lock),
    .addr_code(addr_code),
    .general_pin_one_in(gp1_in),
    .general_pin_one_out(gp1_out),
    .general_pin_one_oe(gp1_oe),
    .general_pin_two_in(gp2_in),
    .general_pin_two_out(gp2_out),
    .general_pin_two_oe(gp2_oe),
    .precharge_backplane(pre_bp),
    .precharge_card(pre_card),
    .connect_enable(connect_sense_reset_in_en),
    .accel_enable(accel_en)
  );
  abb_host u_abb_host (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .link(link.host)
  );
  abb_link_props u_abb_link_props (
    .pclk(pclk),
    .presetn(presetn),
    .scl(link.scl),
    .host_scl_out(link.host_scl_out),
    .host_sda_out(link.host_sda_out),
    .dev_scl_out(link.dev_scl_out),
    .dev_scl_oe(link.dev_scl_oe),
    .dev_sda_out(link.dev_sda_out),
    .dev_sda_oe(link.dev_sda_oe),
    .connect_sense_reset_in(sense),
    .supply_lockout(lock),
    .connect_enable(connect_sense_reset_in_en),
    .accel_enable(accel_en),
    .general_pin_one_oe(gp1_oe),
    .general_pin_two_oe(gp2_oe),
    .precharge_backplane(pre_bp)
  );

  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  task automatic test_done(input string s);
    $display("test %0s done", s);
  endtask : test_done

  // Every read result is matched against the oldest note
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      cur = note_q.pop_front();
      check(40'({pslverr, prdata & cur.m}), 40'({cur.e, cur.v}));
    end
  end

  // One APB transfer; the request stands until pready is seen high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic e,
                    input logic [31:0] v);
    note_q.push_back('{m, e, v});
    apb(a, 1'b0, 32'h0);
  endtask : rd

  // One bus transaction, then the final status under a mask
  task automatic cmd(input logic [6:0] a, input logic r, input logic [7:0] d,
                     input logic [31:0] m, input logic [31:0] v);
    int n;
    apb(abb_pkg::REG_CMD, 1'b1, {16'h0, d, r, a});
    n = 0;
    do begin
      rd(abb_pkg::REG_STATUS, 32'h0, 1'b0, 32'h0);
      n++;
    end while (rdata[abb_pkg::ST_BUSY_BIT] !== 1'b0 && n < 500);
    rd(abb_pkg::REG_STATUS, m, 1'b0, v);
    check(40'({link.scl, link.sda}), 40'(2'b11));
  endtask : cmd

  function automatic logic [1:0] pin_exp(input logic [1:0] mode, input logic val);
    if (mode == abb_pkg::ABB_PIN_OD) return {~val, 1'b0};
    if (mode == abb_pkg::ABB_PIN_PP) return {1'b1, val};
    return 2'b00;
  endfunction : pin_exp

  // Pin drivers and switch enables against one configuration byte
  task automatic cfg_check(input logic [7:0] c);
    check(40'({gp2_oe, gp2_out & gp2_oe, gp1_oe, gp1_out & gp1_oe}),
          40'({pin_exp(c[5:4], c[7]), pin_exp(c[3:2], c[6])}));
    check(40'({connect_sense_reset_in_en, accel_en}), 40'({c[0], c[1]}));
  endtask : cfg_check

  // Hang guard, well past the expected run length
  initial begin
    repeat (80000) @(posedge pclk);
    fails++;
    final_report();
  end

  // Main sequence
  initial begin
    seed = 8762;
    fails = 0;
    n_compared = 0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    presetn = 1'b0;
    sense = 1'b1;
    lock = 1'b0;
    card_lock = 1'b0;
    addr_code = 5'h00;
    gp1_in = 1'b0;
    gp2_in = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    cfg_check(8'hC0);
    rd(abb_pkg::REG_DIV, 32'hFFFF, 1'b0, 32'(abb_pkg::DIV_RESET));
    rd(abb_pkg::REG_STATUS, 32'h7, 1'b0, 32'h0);
    rd(12'h00C, 32'hFFFFFFFF, 1'b1, 32'h0);
    apb(abb_pkg::REG_DIV, 1'b1, 32'h5);
    rd(abb_pkg::REG_DIV, 32'hFFFF, 1'b0, 32'h5);
    test_done("registers");
    // Own address against neighbours differing in one bit
    for (int i = 0; i < 4; i++) begin
      addr_code <= 5'($random(seed));
      repeat (4) @(posedge pclk);
      cmd(own, 1'b0, 8'hC0, 32'h7, 32'h0);
      cmd({2'b01, addr_code}, 1'b0, 8'hC0, 32'h3, 32'h2);
      cmd({abb_pkg::ADDR_TOP, addr_code ^ (5'h01 << i)}, 1'b0, 8'hC0, 32'h3, 32'h2);
    end
    test_done("address");
    // Each pin mode, then read back pin levels and settings
    for (int i = 0; i < 4; i++) begin
      gp1_in <= 1'($random(seed));
      gp2_in <= 1'($random(seed));
      cmd(own, 1'b0, cfgs[i], 32'h7, 32'h0);
      cfg_check(cfgs[i]);
      cmd(own, 1'b1, 8'h00, 32'hFF07, {16'h0, gp2_in, gp1_in, cfgs[i][5:0], 8'h00});
    end
    test_done("pins");
    // Sense low wipes the settings and silences the bus
    cmd(own, 1'b0, 8'h67, 32'h7, 32'h0);
    sense <= 1'b0;
    repeat (6) @(posedge pclk);
    cfg_check(8'hC0);
    cmd(own, 1'b0, 8'h67, 32'h3, 32'h2);
    sense <= 1'b1;
    repeat (6) @(posedge pclk);
    cfg_check(8'hC0);
    cmd(own, 1'b1, 8'h00, 32'hFF07, {16'h0, gp2_in, gp1_in, 6'h00, 8'h00});
    test_done("sense");
    // Lockout: precharge on, switch off, bus ignored
    cmd(own, 1'b0, 8'h67, 32'h7, 32'h0);
    lock <= 1'b1;
    repeat (6) @(posedge pclk);
    check(40'({pre_bp, pre_card, connect_sense_reset_in_en}), 40'(3'b110));
    cmd(own, 1'b0, 8'hC0, 32'h3, 32'h2);
    // Single-supply variant: card lockout moves neither precharge nor switch
    lock <= 1'b0;
    card_lock <= 1'b1;
    repeat (6) @(posedge pclk);
    check(40'({pre_bp, pre_card, connect_sense_reset_in_en}), 40'(3'b001));
    cmd(own, 1'b0, 8'hC0, 32'h7, 32'h0);
    test_done("lockout");
    final_report();
  end
endmodule : test_addressable_bus_buffer_ctrl
